// ### audio_out_pkg.sv
// constants, register map and field layout of the serial audio output block
// Summary of operation
// [R1] audio clock enable divides the system clock by the 5-bit divisor plus one
// [R2] master clock output toggles only while the interface enable bit is set
// [R3] bit and word clocks derive from master clock at 256 or 384 times fs
// [R4] bit and word clocks stay idle until a sample reaches the converter
// [R5] channel-width bit selects 16 or 32 bit clocks per channel
// [R6] polarity bit chooses word-select level for the left channel
// [R7] each 16-bit sample is shifted out serially, msb first
// [R8] justify offset delays the msb; unused slot bits are driven as zero
// [R9] source bit picks decoder buffer when clear, host buffer when set
// [R10] host byte goes to the upper byte, lower byte filled with zero
// [R11] duplication code repeats each host sample 1, 2, 4 or 6 times
// [R12] host sample buffer holds eight bytes
// [R13] request flag sets on count 4 to 3, clears on 4 to 5
// [R14] under-run flag sets when the host buffer becomes empty
// [R15] busy flag shows while the host buffer holds eight bytes
// [R16] decoder buffer takes 16-bit words and requests while it has room
// [R17] clearing request enable stops requests, playback drains the buffer
// [R18] interrupt sources masked separately and gated by a global enable
// [R19] interrupt on each unmasked flag rise; data write clears both flags
// [R20] interrupt flag cleared by hardware on service routine entry
// [R21] software sets master-rate bit to the real master clock multiple
// [R22] polarity set puts left on high word-select, clear on low
// [R23] master-rate bit set means 384 fs, clear means 256 fs
// [R24] channel-width bit set gives 32-bit slots, clear gives 16-bit
// [R25] write to a full host buffer is dropped, contents unchanged
package audio_out_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_FORMAT = 8'h9a;
   localparam logic [7:0] IDX_PATH = 8'h9b;
   localparam logic [7:0] IDX_STATUS = 8'h9c;
   localparam logic [7:0] IDX_VOICE = 8'h9d;
   localparam logic [7:0] IDX_DIVIDER = 8'hec;
   localparam logic [7:0] IDX_IRQ = 8'hed;
   localparam int unsigned ADDR_W = 10;
   // format control fields
   localparam int unsigned FMT_JUST_LSB = 3;
   localparam int unsigned FMT_POL = 2;
   localparam int unsigned FMT_CHANNEL_WIDTH_SELECT = 1;
   localparam int unsigned FMT_HLR = 0;
   // path control fields
   localparam int unsigned PATH_SRC = 7;
   localparam int unsigned PATH_DRQEN = 6;
   localparam int unsigned PATH_SAMPLE_REQUEST_MASK = 5;
   localparam int unsigned PATH_UNDERRUN_MASK = 4;
   localparam int unsigned PATH_DUP_LSB = 1;
   localparam int unsigned PATH_EN = 0;
   localparam logic [7:0] PATH_WMASK = 8'hf7;
   // status fields
   localparam int unsigned STA_SAMPLE_REQUEST_FLAG = 7;
   localparam int unsigned STA_UNDERRUN_FLAG = 6;
   localparam int unsigned STA_BUSY = 5;
   // interrupt control fields
   localparam int unsigned IRQ_GEN = 0;
   localparam int unsigned IRQ_FLAG = 1;
   // reset values
   localparam logic [7:0] FORMAT_RST = 8'h00;
   localparam logic [7:0] PATH_RST = 8'hb2;
   localparam logic [7:0] VOICE_RST = 8'hff;
   localparam logic [4:0] DIVIDER_RST = 5'h00;
   localparam logic IRQ_GEN_RST = 1'b0;
   // audio clock enable ticks per bit-clock half period for 16-bit slots
   localparam logic [3:0] HALF_BIT_256 = 4'h8;
   localparam logic [3:0] HALF_BIT_384 = 4'hc;
   // buffers
   localparam logic [3:0] HOST_DEPTH = 4'h8;
   localparam logic [3:0] SAMPLE_REQUEST_FLAG_LEVEL = 4'h4;
   localparam logic [2:0] MP3_DEPTH = 3'h4;
   // repeats minus one for duplication codes 00, 01, 10, 11
   localparam logic [2:0] REP_X1 = 3'h0;
   localparam logic [2:0] REP_X2 = 3'h1;
   localparam logic [2:0] REP_X4 = 3'h3;
   localparam logic [2:0] REP_X6 = 3'h5;
   typedef enum logic {CONV_IDLE = 1'b0, CONV_RUN = 1'b1} conv_state_e;
endpackage : audio_out_pkg

// ### serial_audio_output.sv
// serial audio output: apb registers, buffers, clock generator and data converter
`timescale 1ns/1ps
module serial_audio_output (
   input wire logic clk, // 10 MHz system clock
   input wire logic rst, // asynchronous reset, active high
   input wire logic [audio_out_pkg::ADDR_W-1:0] paddr, // apb byte address
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic [15:0] mp3_data, // decoded sample word
   input wire logic mp3_valid, // decoded word present
   output logic mp3_req, // decoder buffer has room
   input wire logic isr_ack, // service routine entered
   output logic audio_irq, // audio interrupt request
   output logic master_clk_out, // dac system clock
   output logic bit_clock_out, // serial bit clock
   output logic word_select_out, // channel select
   output logic serial_data_out // serial data
);
   logic [7:0] fmt_q;
   logic [7:0] path_q;
   logic [7:0] voice_q;
   logic [4:0] div_q;
   logic gen_q;
   logic irq_q;
   logic [31:0] prdata_q;
   logic [7:0] hbuf [0:7];
   logic [2:0] hwr_q;
   logic [2:0] hrd_q;
   logic [3:0] hcnt_q;
   logic [3:0] hcnt_d;
   logic sample_request_flag_q;
   logic underrun_flag_q;
   logic [15:0] mbuf [0:3];
   logic [1:0] mwr_q;
   logic [1:0] mrd_q;
   logic [2:0] mcnt_q;
   logic [2:0] mcnt_d;
   logic [4:0] dcnt_q;
   logic mclk_q;
   logic [3:0] hb_q;
   logic bclk_q;
   logic [5:0] pos_q;
   logic [5:0] pos_d;
   logic [2:0] rep_q;
   logic [15:0] left_q;
   logic [15:0] right_q;
   logic [15:0] left_d;
   logic [15:0] right_d;
   logic sdo_q;
   logic ws_q;
   audio_out_pkg::conv_state_e st_q;

   // apb decode
   logic [7:0] idx;
   logic setup_ph;
   logic wr_ph;
   logic hit_fmt;
   logic hit_path;
   logic hit_sta;
   logic hit_voice;
   logic hit_div;
   logic hit_irq;
   logic mapped;
   logic [7:0] rd_mux;
   assign idx = paddr[9:2];
   assign setup_ph = psel & ~penable;
   assign wr_ph = psel & penable & pwrite;
   assign hit_fmt = idx == audio_out_pkg::IDX_FORMAT;
   assign hit_path = idx == audio_out_pkg::IDX_PATH;
   assign hit_sta = idx == audio_out_pkg::IDX_STATUS;
   assign hit_voice = idx == audio_out_pkg::IDX_VOICE;
   assign hit_div = idx == audio_out_pkg::IDX_DIVIDER;
   assign hit_irq = idx == audio_out_pkg::IDX_IRQ;
   assign mapped = (paddr[1:0] == 2'b00) &
                   (hit_fmt | hit_path | hit_sta | hit_voice | hit_div | hit_irq);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_q;

   // configuration fields
   logic [4:0] just;
   logic left_level_polarity;
   logic channel_width_select;
   logic master_rate_select;
   logic src;
   logic drq_en;
   logic sample_request_mask;
   logic underrun_mask;
   logic [1:0] dup;
   logic aud_en;
   logic busy;
   assign just = fmt_q[audio_out_pkg::FMT_JUST_LSB +: 5];
   assign left_level_polarity = fmt_q[audio_out_pkg::FMT_POL];
   assign channel_width_select = fmt_q[audio_out_pkg::FMT_CHANNEL_WIDTH_SELECT];
   assign master_rate_select = fmt_q[audio_out_pkg::FMT_HLR];
   assign src = path_q[audio_out_pkg::PATH_SRC];
   assign drq_en = path_q[audio_out_pkg::PATH_DRQEN];
   assign sample_request_mask = path_q[audio_out_pkg::PATH_SAMPLE_REQUEST_MASK];
   assign underrun_mask = path_q[audio_out_pkg::PATH_UNDERRUN_MASK];
   assign dup = path_q[audio_out_pkg::PATH_DUP_LSB +: 2];
   assign aud_en = path_q[audio_out_pkg::PATH_EN];
   // [R15] busy flag
   assign busy = hcnt_q == audio_out_pkg::HOST_DEPTH;

   assign rd_mux = hit_fmt ? fmt_q :
                   hit_path ? path_q :
                   hit_sta ? {sample_request_flag_q, underrun_flag_q, busy, 5'h00} :
                   hit_voice ? voice_q :
                   hit_div ? {3'h0, div_q} :
                   hit_irq ? {6'h00, irq_q, gen_q} : 8'h00;

   logic vwr;
   assign vwr = wr_ph & mapped & hit_voice;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         fmt_q <= audio_out_pkg::FORMAT_RST;
         path_q <= audio_out_pkg::PATH_RST;
         voice_q <= audio_out_pkg::VOICE_RST;
         div_q <= audio_out_pkg::DIVIDER_RST;
         gen_q <= audio_out_pkg::IRQ_GEN_RST;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         if (wr_ph & mapped & hit_fmt) fmt_q <= pwdata[7:0];
         if (wr_ph & mapped & hit_path) path_q <= pwdata[7:0] & audio_out_pkg::PATH_WMASK;
         if (vwr) voice_q <= pwdata[7:0];
         if (wr_ph & mapped & hit_div) div_q <= pwdata[4:0];
         if (wr_ph & mapped & hit_irq) gen_q <= pwdata[audio_out_pkg::IRQ_GEN];
         if (setup_ph) prdata_q <= {24'h00_0000, rd_mux};
      end
   end

   // [R1] audio clock enable from the 5-bit divisor
   logic tick;
   assign tick = aud_en & (dcnt_q == div_q);
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst) dcnt_q <= 5'h00;
      else if (tick | ~aud_en) dcnt_q <= 5'h00;
      else dcnt_q <= dcnt_q + 5'h01;
   end

   // [R2] master clock runs only while enabled
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst) mclk_q <= 1'b0;
      else if (~aud_en) mclk_q <= 1'b0;
      else if (tick) mclk_q <= ~mclk_q;
   end
   assign master_clk_out = mclk_q;

   // [R3] [R23] half bit period in ticks: 256 or 384 fs over 32 or 64 bits a frame
   logic [3:0] half_base;
   logic [3:0] half_len;
   assign half_base = master_rate_select ? audio_out_pkg::HALF_BIT_384 : audio_out_pkg::HALF_BIT_256;
   // [R24] wider slots halve the bit period
   assign half_len = channel_width_select ? {1'b0, half_base[3:1]} : half_base;

   logic run;
   logic hb_end;
   logic fall;
   logic frame_last;
   logic host_avail;
   logic mp3_avail;
   logic avail;
   logic load;
   logic stop;
   logic hpop;
   logic mpop;
   logic hpush;
   logic mpush;
   logic [2:0] rep_new;
   assign run = st_q == audio_out_pkg::CONV_RUN;
   assign hb_end = tick & run & (hb_q == half_len - 4'h1);
   assign fall = hb_end & bclk_q;
   // [R5] frame spans two 16-bit or two 32-bit slots
   assign frame_last = pos_q == (channel_width_select ? 6'd63 : 6'd31);
   assign host_avail = (rep_q != 3'h0) | (hcnt_q != 4'h0);
   assign mp3_avail = mcnt_q >= 3'h2;
   // [R9] source select
   assign avail = src ? host_avail : mp3_avail;
   // [R4] clocks start with the first sample and stop when none is left
   assign load = aud_en & avail & ((~run) | (fall & frame_last));
   assign stop = ~aud_en | (fall & frame_last & ~avail);
   assign hpop = load & src & (rep_q == 3'h0);
   assign mpop = load & ~src;
   // [R25] full buffer drops the write
   assign hpush = vwr & ~busy;

   // [R11] repeats per host sample
   assign rep_new = (dup == 2'b00) ? audio_out_pkg::REP_X1 :
                    (dup == 2'b01) ? audio_out_pkg::REP_X2 :
                    (dup == 2'b10) ? audio_out_pkg::REP_X4 : audio_out_pkg::REP_X6;

   // [R10] host byte widened to the upper byte, mono on both channels
   always_comb
   begin
      left_d = left_q;
      right_d = right_q;
      if (hpop)
      begin
         left_d = {hbuf[hrd_q], 8'h00};
         right_d = {hbuf[hrd_q], 8'h00};
      end
      else if (mpop)
      begin
         left_d = mbuf[mrd_q];
         right_d = mbuf[mrd_q + 2'h1];
      end
   end

   assign pos_d = load ? 6'd0 : (fall ? pos_q + 6'd1 : pos_q);

   // [R7] serial bit for a frame position, msb first
   // [R8] justify offset shifts the msb; bits outside the sample are zero
   function automatic logic data_bit(input logic [5:0] p, input logic sz,
                                     input logic [4:0] j, input logic [15:0] l,
                                     input logic [15:0] r);
      logic [4:0] slot;
      logic ch;
      logic [5:0] rel;
      slot = sz ? p[4:0] : {1'b0, p[3:0]};
      ch = sz ? p[5] : p[4];
      rel = {1'b0, slot} - {1'b0, j};
      if ((slot < j) || (rel > 6'd15)) data_bit = 1'b0;
      else if (ch) data_bit = r[4'hf - rel[3:0]];
      else data_bit = l[4'hf - rel[3:0]];
   endfunction : data_bit

   logic chan_d;
   assign chan_d = channel_width_select ? pos_d[5] : pos_d[4];

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_q <= audio_out_pkg::CONV_IDLE;
         hb_q <= 4'h0;
         bclk_q <= 1'b0;
         pos_q <= 6'd0;
         rep_q <= 3'h0;
         left_q <= 16'h0000;
         right_q <= 16'h0000;
         sdo_q <= 1'b0;
         ws_q <= 1'b0;
      end
      else
      begin
         left_q <= left_d;
         right_q <= right_d;
         pos_q <= pos_d;
         if (load & src) rep_q <= (rep_q != 3'h0) ? rep_q - 3'h1 : rep_new;
         else if (~src) rep_q <= 3'h0;
         if (stop & ~load)
         begin
            st_q <= audio_out_pkg::CONV_IDLE;
            bclk_q <= 1'b0;
            hb_q <= 4'h0;
         end
         else
         begin
            if (load) st_q <= audio_out_pkg::CONV_RUN;
            if (hb_end) bclk_q <= ~bclk_q;
            if (hb_end) hb_q <= 4'h0;
            else if (tick & run) hb_q <= hb_q + 4'h1;
         end
         if (load | fall)
         begin
            sdo_q <= data_bit(pos_d, channel_width_select, just, left_d, right_d);
            // [R6] [R22] left slot on high select when polarity set
            ws_q <= chan_d ? ~left_level_polarity : left_level_polarity;
         end
      end
   end
   assign bit_clock_out = bclk_q;
   assign word_select_out = ws_q;
   assign serial_data_out = sdo_q;

   // [R12] eight-byte host buffer
   always_ff @(posedge clk)
   begin
      if (hpush) hbuf[hwr_q] <= pwdata[7:0];
   end
   assign hcnt_d = hcnt_q + {3'h0, hpush} - {3'h0, hpop};
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         hwr_q <= 3'h0;
         hrd_q <= 3'h0;
         hcnt_q <= 4'h0;
      end
      else
      begin
         if (hpush) hwr_q <= hwr_q + 3'h1;
         if (hpop) hrd_q <= hrd_q + 3'h1;
         hcnt_q <= hcnt_d;
      end
   end

   // [R13] request flag on count crossing; set wins over the data-write clear
   logic sample_request_flag_set;
   logic underrun_flag_set;
   assign sample_request_flag_set = src & (hcnt_q == audio_out_pkg::SAMPLE_REQUEST_FLAG_LEVEL) &
                     (hcnt_d == audio_out_pkg::SAMPLE_REQUEST_FLAG_LEVEL - 4'h1);
   // [R14] under-run when the buffer drains
   assign underrun_flag_set = src & (hcnt_q == 4'h1) & (hcnt_d == 4'h0);
   logic sample_request_flag_clr;
   assign sample_request_flag_clr = vwr | ((hcnt_q == audio_out_pkg::SAMPLE_REQUEST_FLAG_LEVEL) &
                            (hcnt_d == audio_out_pkg::SAMPLE_REQUEST_FLAG_LEVEL + 4'h1));
   // [R18] masked sources, global enable
   logic irq_set;
   assign irq_set = gen_q & src & ((sample_request_flag_set & ~sample_request_mask) | (underrun_flag_set & ~underrun_mask));
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sample_request_flag_q <= 1'b0;
         underrun_flag_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         // [R19] data write clears both source flags
         sample_request_flag_q <= sample_request_flag_set | (sample_request_flag_q & ~sample_request_flag_clr);
         underrun_flag_q <= underrun_flag_set | (underrun_flag_q & ~vwr);
         // [R20] service entry clears the interrupt flag
         irq_q <= irq_set | (irq_q & ~isr_ack);
      end
   end
   assign audio_irq = irq_q;

   // [R16] decoder buffer requests while it has room
   // [R17] request enable gates requests only; playback drains what is held
   assign mp3_req = drq_en & (mcnt_q < audio_out_pkg::MP3_DEPTH);
   assign mpush = mp3_valid & mp3_req;
   assign mcnt_d = mcnt_q + {2'h0, mpush} - {mpop, 1'b0};
   always_ff @(posedge clk)
   begin
      if (mpush) mbuf[mwr_q] <= mp3_data;
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mwr_q <= 2'h0;
         mrd_q <= 2'h0;
         mcnt_q <= 3'h0;
      end
      else
      begin
         if (mpush) mwr_q <= mwr_q + 2'h1;
         if (mpop) mrd_q <= mrd_q + 2'h2;
         mcnt_q <= mcnt_d;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_full_write_drop: assert property (vwr && busy && !hpop |=> busy && $stable(hwr_q)) // [R25]
      else $error("write to full host buffer changed it");
   a_sample_request_flag_set_cross: assert property (sample_request_flag_set |=> sample_request_flag_q) // [R13]
      else $error("request flag missed the 4 to 3 crossing");
   a_sample_request_flag_clr_cross: assert property (hcnt_q == 4'h4 && hcnt_d == 4'h5 && !sample_request_flag_set
                                      |=> !sample_request_flag_q) // [R13]
      else $error("request flag stayed on 4 to 5 crossing");
   a_underrun_flag_on_empty: assert property (src && hcnt_q == 4'h1 && hpop && !hpush
                                     |=> underrun_flag_q && hcnt_q == 4'h0) // [R14]
      else $error("under-run not flagged on empty");
   a_req_paused: assert property (!drq_en |-> !mp3_req) // [R17]
      else $error("decoder request while disabled");
   a_mclk_off: assert property (!aud_en |=> !master_clk_out) // [R2]
      else $error("master clock runs while disabled");
   a_bclk_idle: assert property (!run && !load |=> !bit_clock_out) // [R4]
      else $error("bit clock runs without data");
   a_irq_ack_clear: assert property (isr_ack && !irq_set |=> !audio_irq) // [R20]
      else $error("interrupt flag not cleared on entry");
   a_host_widen: assert property (hpop |=> left_q[7:0] == 8'h00 && left_q == right_q) // [R10]
      else $error("host sample not widened");
   a_ws_polarity: assert property (load |=> word_select_out == $past(left_level_polarity)) // [R22]
      else $error("left slot word select level wrong");
   a_dup_repeat: assert property (hpop && dup == 2'b11 |=> rep_q == 3'h5) // [R11]
      else $error("duplication count wrong");
   c_host_frame: cover property (hpop ##1 run);
   c_mp3_frame: cover property (mpop ##1 run);
   c_irq_rise: cover property (!audio_irq ##1 audio_irq);
   c_full_write: cover property (vwr && busy);
endmodule : serial_audio_output

// ### dac_receiver.sv
// receiving converter model: rebuilds left and right samples from the serial stream
`timescale 1ns/1ps
module dac_receiver (
   input wire logic rst, // model reset, active high
   input wire logic left_level_polarity, // word-select level of the left slot
   input wire logic bclk, // serial bit clock
   input wire logic ws, // word select
   input wire logic sdata, // serial data
   output logic [15:0] left_word, // last left sample
   output logic [15:0] right_word, // last right sample
   output int frames // completed frames
);
   logic [15:0] shift_q;
   logic last_ws_q;
   int nbits;
   // only the first 16 bits of a slot are kept, so wider slots still decode
   always @(posedge bclk or posedge rst)
   begin
      if (rst)
      begin
         last_ws_q = ~left_level_polarity;
         nbits = 0;
         frames = 0;
         left_word = 16'h0000;
         right_word = 16'h0000;
      end
      else
      begin
         if (ws !== last_ws_q)
            nbits = 0;
         last_ws_q = ws;
         shift_q = {shift_q[14:0], sdata};
         nbits++;
         if (nbits == 16 && ws === left_level_polarity)
            left_word = shift_q;
         if (nbits == 16 && ws !== left_level_polarity)
         begin
            right_word = shift_q;
            frames++;
         end
      end
   end
endmodule : dac_receiver

// ### tb_serial_audio_output.sv
// self-checking bench for the serial audio output block
`timescale 1ns/1ps
module tb_serial_audio_output;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [9:0] paddr = 10'h000;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mp3_valid = 1'b0, isr_ack = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [15:0] mp3_data = 16'h0000;
   logic dac_rst = 1'b0, dac_pol = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, mp3_req, audio_irq, mclk, bclk, ws, sdo;
   logic [15:0] left_word, right_word;
   int frames;
   int fail_count = 0;
   int comparisons = 0;

   always #50 clk = ~clk;

   serial_audio_output serial_audio_output_inst (
      .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mp3_data(mp3_data), .mp3_valid(mp3_valid), .mp3_req(mp3_req),
      .isr_ack(isr_ack), .audio_irq(audio_irq), .master_clk_out(mclk),
      .bit_clock_out(bclk), .word_select_out(ws), .serial_data_out(sdo)
   );
   dac_receiver dac_receiver_inst (
      .rst(dac_rst), .left_level_polarity(dac_pol), .bclk(bclk), .ws(ws), .sdata(sdo),
      .left_word(left_word), .right_word(right_word), .frames(frames)
   );

   task automatic summarize;
      if (fail_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic give_up;
      fail_count++;
      summarize();
   endtask : give_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk

   task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge clk);
      paddr <= {idx, 2'b00};
      pwrite <= w;
      pwdata <= {24'h00_0000, d};
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50)
         give_up();
      @(negedge clk);
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(idx, 1'b1, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(idx, 1'b0, 8'h00, r, e);
      chk(r, exp);
   endtask : rd

   task automatic wait_frames(input int target);
      int n;
      n = 0;
      while (frames < target && n < 20000)
      begin
         @(posedge clk);
         n++;
      end
      if (frames < target)
         give_up();
   endtask : wait_frames

   // rise-to-rise period in clocks of master (0) or bit (1) clock
   task automatic period(input logic pick, input int exp);
      int t;
      repeat (2)
      begin
         t = 0;
         while ((pick ? bclk : mclk) === 1'b1 && t < 200)
         begin
            @(negedge clk);
            t++;
         end
         while ((pick ? bclk : mclk) !== 1'b1 && t < 200)
         begin
            @(negedge clk);
            t++;
         end
      end
      chk(t, exp);
   endtask : period

   task automatic send(input logic [15:0] w);
      int n;
      @(posedge clk);
      mp3_data <= w;
      mp3_valid <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (mp3_req !== 1'b1 && n < 5000);
      mp3_valid <= 1'b0;
      if (n >= 5000)
         give_up();
   endtask : send

   task automatic t_regs;
      logic [31:0] r;
      logic e;
      chk(mp3_req, 1'b0);
      rd(audio_out_pkg::IDX_FORMAT, 32'h0000_0000);
      rd(audio_out_pkg::IDX_PATH, 32'h0000_00b2);
      rd(audio_out_pkg::IDX_VOICE, 32'h0000_00ff);
      rd(audio_out_pkg::IDX_DIVIDER, 32'h0000_0000);
      rd(audio_out_pkg::IDX_IRQ, 32'h0000_0000);
      wr(audio_out_pkg::IDX_STATUS, 8'hff);
      rd(audio_out_pkg::IDX_STATUS, 32'h0000_0000);
      apb(8'h00, 1'b0, 8'h00, r, e);
      chk(e, 1'b1);
      chk(r, 32'h0000_0000);
   endtask : t_regs

   task automatic t_host;
      int f0;
      wr(audio_out_pkg::IDX_DIVIDER, 8'h01);
      wr(audio_out_pkg::IDX_IRQ, 8'h01);
      wr(audio_out_pkg::IDX_PATH, 8'h80);
      chk(mclk, 1'b0);
      for (int k = 0; k < 9; k++)
         wr(audio_out_pkg::IDX_VOICE, 8'h10 + k[7:0]);
      rd(audio_out_pkg::IDX_STATUS, 32'h0000_0020);
      f0 = frames;
      wr(audio_out_pkg::IDX_PATH, 8'h81);
      period(1'b0, 4);
      period(1'b1, 32);
      for (int k = 0; k < 8; k++)
      begin
         wait_frames(f0 + k + 1);
         chk(left_word, {8'h10 + k[7:0], 8'h00});
         chk(right_word, {8'h10 + k[7:0], 8'h00});
         if (k == 1)
            rd(audio_out_pkg::IDX_STATUS, 32'h0000_0000);
      end
      repeat (2000) @(posedge clk);
      chk(frames, f0 + 8);
      rd(audio_out_pkg::IDX_STATUS, 32'h0000_00c0);
      chk(audio_irq, 1'b1);
      @(posedge clk);
      isr_ack <= 1'b1;
      @(posedge clk);
      isr_ack <= 1'b0;
      @(negedge clk);
      chk(audio_irq, 1'b0);
      rd(audio_out_pkg::IDX_STATUS, 32'h0000_00c0);
      wr(audio_out_pkg::IDX_PATH, 8'h80);
      wr(audio_out_pkg::IDX_VOICE, 8'h5a);
      rd(audio_out_pkg::IDX_STATUS, 32'h0000_0000);
   endtask : t_host

   task automatic t_dup;
      int f0;
      f0 = frames;
      wr(audio_out_pkg::IDX_FORMAT, 8'h08);
      wr(audio_out_pkg::IDX_PATH, 8'hb7);
      wait_frames(f0 + 6);
      chk(left_word, 32'h0000_2d00);
      repeat (2000) @(posedge clk);
      chk(frames, f0 + 6);
      rd(audio_out_pkg::IDX_STATUS, 32'h0000_0040);
      chk(audio_irq, 1'b0);
      wr(audio_out_pkg::IDX_PATH, 8'hb5);
      wr(audio_out_pkg::IDX_VOICE, 8'h66);
      wait_frames(f0 + 10);
      chk(left_word, 32'h0000_3300);
      repeat (2000) @(posedge clk);
      chk(frames, f0 + 10);
   endtask : t_dup

   task automatic t_mp3;
      logic seen;
      wr(audio_out_pkg::IDX_FORMAT, 8'h07);
      wr(audio_out_pkg::IDX_PATH, 8'h01);
      @(posedge clk);
      dac_pol <= 1'b1;
      @(posedge clk);
      dac_rst <= 1'b1;
      @(posedge clk);
      dac_rst <= 1'b0;
      chk(mp3_req, 1'b0);
      seen = 1'b0;
      repeat (100)
      begin
         @(posedge clk);
         seen = seen | bclk;
      end
      chk(seen, 1'b0);
      wr(audio_out_pkg::IDX_PATH, 8'h41);
      chk(mp3_req, 1'b1);
      send(16'h1234);
      send(16'ha5c3);
      send(16'h0f0f);
      send(16'hf00d);
      wr(audio_out_pkg::IDX_PATH, 8'h01);
      chk(mp3_req, 1'b0);
      period(1'b1, 24);
      wait_frames(1);
      chk(left_word, 32'h0000_1234);
      chk(right_word, 32'h0000_a5c3);
      wait_frames(2);
      chk(left_word, 32'h0000_0f0f);
      chk(right_word, 32'h0000_f00d);
   endtask : t_mp3

   initial
   begin
      @(posedge clk);
      dac_rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      dac_rst <= 1'b0;
      t_regs();
      t_host();
      t_dup();
      t_mp3();
      summarize();
   end
endmodule : tb_serial_audio_output
